// >>> amx_pkg.sv
`default_nettype none
package amx_pkg;
  localparam int amx_data_width = 8;
  localparam int amx_addr_width = 7;
  localparam int amx_file_depth = 128;
  localparam logic [7:0] amx_accum_reset = 8'h00;
  localparam logic [7:0] amx_file_reset = 8'h00;
  localparam logic amx_zero_reset = 1'b0;
  localparam logic amx_dest_accum = 1'b0;
  localparam logic amx_dest_file = 1'b1;
  localparam int amx_op_cycles = 1;

  typedef enum logic [2:0]
  {
    amx_idle_op = 3'b000,
    amx_increment_file_op = 3'b001,
    amx_or_accumulator_with_file_op = 3'b010,
    amx_move_file_op = 3'b011,
    amx_store_accumulator_op = 3'b100,
    amx_load_literal_op = 3'b101
  } amx_op_type;
endpackage : amx_pkg
`default_nettype wire

// >>> amx_exec.sv
`timescale 1ns/1ps
`default_nettype none
module amx_exec
  import amx_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic op_valid,
  input wire logic [2:0] op_code,
  input wire logic [6:0] file_addr,
  input wire logic dest_bit,
  input wire logic [7:0] literal,
  output logic [7:0] accum,
  output logic zero_flag,
  output logic [7:0] file_peek,
  output logic op_done
);
  logic [7:0] file_mem [0:amx_file_depth-1];
  logic [7:0] next_accum;
  logic next_zero;

  // operand fetch and decode
  wire [7:0] file_val = file_mem[file_addr];
  wire is_inc = op_valid && op_code == amx_increment_file_op;
  wire is_or = op_valid && op_code == amx_or_accumulator_with_file_op;
  wire is_mov = op_valid && op_code == amx_move_file_op;
  wire is_store = op_valid && op_code == amx_store_accumulator_op;
  wire is_lit = op_valid && op_code == amx_load_literal_op;
  wire alu_op = is_inc || is_or || is_mov;

  // result select; move passes the value untouched so a write-back is a pure zero test
  wire [7:0] inc_result = 8'(file_val + 8'h01);
  wire [7:0] or_result = accum | file_val;
  wire [7:0] alu_result = is_inc ? inc_result : (is_or ? or_result : file_val);
  wire to_file = alu_op && dest_bit == amx_dest_file;
  wire to_accum = alu_op && dest_bit == amx_dest_accum;

  // next state; store, literal and idle leave the zero flag alone
  always_comb
  begin
    next_accum = accum;
    next_zero = zero_flag;
    if (to_accum)
      next_accum = alu_result;
    else if (is_lit)
      next_accum = literal;
    if (alu_op)
      next_zero = alu_result == 8'h00;
  end

  // accumulator and flag, one cycle per instruction
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      accum <= amx_accum_reset;
      zero_flag <= amx_zero_reset;
    end
    else
    begin
      accum <= next_accum;
      zero_flag <= next_zero;
    end
  end

  // file register array; no reset loop to keep it a plain memory
  always_ff @(posedge ref_clk)
  begin
    if (to_file)
      file_mem[file_addr] <= alu_result;
    else if (is_store)
      file_mem[file_addr] <= accum;
  end

  // completion and observed register, registered
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      op_done <= 1'b0;
      file_peek <= amx_file_reset;
    end
    else
    begin
      op_done <= op_valid;
      file_peek <= file_val;
    end
  end

  // checker support: the address taken at the last edge, so a written register can be read back
  // one cycle later without indexing the array through a sampled-value function
  logic [6:0] check_addr;
  wire [7:0] file_at_check = file_mem[check_addr];

  always_ff @(posedge ref_clk)
  begin
    check_addr <= file_addr;
  end

  // one taking edge per instruction, split by where the result goes
  sequence s_inc_accum;
    is_inc && dest_bit == amx_dest_accum;
  endsequence

  sequence s_inc_file;
    is_inc && dest_bit == amx_dest_file;
  endsequence

  sequence s_or_accum;
    is_or && dest_bit == amx_dest_accum;
  endsequence

  sequence s_or_file;
    is_or && dest_bit == amx_dest_file;
  endsequence

  sequence s_mov_accum;
    is_mov && dest_bit == amx_dest_accum;
  endsequence

  sequence s_mov_file;
    is_mov && dest_bit == amx_dest_file;
  endsequence

  // a zero test by write-back, then a read of the same register on the next edge
  sequence s_rewrite_read;
    s_mov_file ##1 (is_mov && dest_bit == amx_dest_accum && file_addr == check_addr);
  endsequence

  // reset values are checked without the disable, since they are what reset is for
  a_reset_values: assert property (@(posedge ref_clk)
    reset |=> accum == amx_accum_reset && zero_flag == amx_zero_reset && !op_done && file_peek == amx_file_reset)
    else $error("reset values wrong");

  // increment: sum to the chosen destination, zero flag from the wrapped sum
  // the checks rebuild the sum from the operand rather than reusing the adder
  a_inc_result: assert property (@(posedge ref_clk) disable iff (reset)
    s_inc_accum |=> accum == 8'($past(file_val) + 8'h01))
    else $error("increment result wrong");

  a_inc_zero: assert property (@(posedge ref_clk) disable iff (reset)
    is_inc |=> zero_flag == ($past(file_val) == 8'hff))
    else $error("increment zero flag wrong");

  a_inc_write: assert property (@(posedge ref_clk) disable iff (reset)
    s_inc_file |=> file_at_check == 8'($past(file_val) + 8'h01))
    else $error("increment write-back wrong");

  // or: accumulator and register combined, to either destination
  a_or_result: assert property (@(posedge ref_clk) disable iff (reset)
    s_or_accum |=> accum == ($past(accum) | $past(file_val)))
    else $error("or result wrong");

  a_or_zero: assert property (@(posedge ref_clk) disable iff (reset)
    is_or |=> zero_flag == (($past(accum) | $past(file_val)) == 8'h00))
    else $error("or zero flag wrong");

  a_or_write: assert property (@(posedge ref_clk) disable iff (reset)
    s_or_file |=> file_at_check == ($past(accum) | $past(file_val)))
    else $error("or write-back wrong");

  // move: value passes untouched, flag set in both directions
  // a write-back must not disturb the register, or the zero test would corrupt it
  a_mov_result: assert property (@(posedge ref_clk) disable iff (reset)
    s_mov_accum |=> accum == $past(file_val))
    else $error("move result wrong");

  a_mov_zero: assert property (@(posedge ref_clk) disable iff (reset)
    is_mov |=> zero_flag == ($past(file_val) == 8'h00))
    else $error("move zero flag wrong");

  a_mov_keep: assert property (@(posedge ref_clk) disable iff (reset)
    s_mov_file |=> accum == $past(accum))
    else $error("move to file touched accum");

  a_mov_write: assert property (@(posedge ref_clk) disable iff (reset)
    s_mov_file |=> file_at_check == $past(file_val))
    else $error("move write-back changed register");

  a_rewrite_read: assert property (@(posedge ref_clk) disable iff (reset)
    s_rewrite_read |=> accum == $past(file_val, 2))
    else $error("register changed by zero test");

  // store and literal load: data moves, flags stay
  a_store_write: assert property (@(posedge ref_clk) disable iff (reset)
    is_store |=> file_at_check == $past(accum))
    else $error("store data wrong");

  a_store_flag: assert property (@(posedge ref_clk) disable iff (reset)
    is_store |=> zero_flag == $past(zero_flag) && accum == $past(accum))
    else $error("store changed state");

  a_lit_load: assert property (@(posedge ref_clk) disable iff (reset)
    is_lit |=> accum == $past(literal) && zero_flag == $past(zero_flag))
    else $error("literal load wrong");

  // destination bit picks exactly one target
  a_dest_file: assert property (@(posedge ref_clk) disable iff (reset)
    to_file |=> accum == $past(accum))
    else $error("file destination changed accum");

  a_dest_accum: assert property (@(posedge ref_clk) disable iff (reset)
    to_accum |=> file_at_check == $past(file_val))
    else $error("accum destination changed register");

  // idle and undefined codes: nothing moves, completion still pulses once
  a_idle_none: assert property (@(posedge ref_clk) disable iff (reset)
    !is_lit && !to_accum |=> accum == $past(accum))
    else $error("accum changed without cause");

  a_flag_keep: assert property (@(posedge ref_clk) disable iff (reset)
    !alu_op |=> zero_flag == $past(zero_flag))
    else $error("zero flag changed without cause");

  a_done_time: assert property (@(posedge ref_clk) disable iff (reset)
    op_valid |=> op_done)
    else $error("instruction not done in one cycle");

  a_done_drop: assert property (@(posedge ref_clk) disable iff (reset)
    !op_valid |=> !op_done)
    else $error("done without an instruction");
endmodule : amx_exec
`default_nettype wire

// >>> test_accumulator_move_inc_or_exec.sv
`timescale 1ns/1ps
`default_nettype none
module test_accumulator_move_inc_or_exec
  import amx_pkg::*;
;
  logic ref_clk = 0, reset = 1, op_valid = 0, dest_bit = 0;
  logic [2:0] op_code = 3'h0;
  logic [6:0] file_addr = 7'h00;
  logic [7:0] literal = 8'h00, ea = 8'h00;
  logic ez = 1'b0;
  wire logic [7:0] accum, file_peek;
  wire logic zero_flag, op_done;
  int n_errors = 0, cmp_count = 0;
  amx_exec dut_u (.ref_clk(ref_clk), .reset(reset), .op_valid(op_valid), .op_code(op_code),
    .file_addr(file_addr), .dest_bit(dest_bit), .literal(literal), .accum(accum),
    .zero_flag(zero_flag), .file_peek(file_peek), .op_done(op_done));
  // 20 ns clock
  initial forever #10 ref_clk = ~ref_clk;
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e)
    begin
      n_errors++;
      $display("FAIL %0t saw %h want %h", $time, s, e);
    end
  endtask : chk
  // one op per cycle, held until the next call so ops run back to back
  task automatic ex(input amx_op_type c, input logic [6:0] a, input logic d, input logic [7:0] k,
    input logic [7:0] na, input logic nz);
    op_valid = 1'b1;
    op_code = c;
    file_addr = a;
    dest_bit = d;
    literal = k;
    ea = na;
    ez = nz;
    @(negedge ref_clk);
    chk(accum, ea);
    chk({7'h00, zero_flag}, {7'h00, ez});
    chk({7'h00, op_done}, 8'h01);
  endtask : ex
  // peek lags the address by a cycle, so two idle cycles
  task automatic peek(input logic [6:0] a, input logic [7:0] e);
    ex(amx_idle_op, a, 1'b0, 8'h00, ea, ez);
    ex(amx_idle_op, a, 1'b0, 8'h00, ea, ez);
    chk(file_peek, e);
  endtask : peek
  task automatic summarize;
    if (n_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  // a hang ends the run instead of stalling it
  initial
  begin
    repeat (2000) @(posedge ref_clk);
    n_errors++;
    summarize();
  end
  // reset: outputs sit at their reset values while held; accum, zero_flag and op_done stay there until the first op
  task automatic sc_reset;
    repeat (15) @(negedge ref_clk);
    chk(accum, amx_accum_reset);
    chk({6'h00, zero_flag, op_done}, {6'h00, amx_zero_reset, 1'b0});
    chk(file_peek, amx_file_reset);
    @(negedge ref_clk);
    reset = 1'b0;
    @(negedge ref_clk);
    chk(accum, amx_accum_reset);
    chk({6'h00, zero_flag, op_done}, {6'h00, amx_zero_reset, 1'b0});
  endtask : sc_reset
  // literal loads and stores seed two registers; unused address and destination stay zero
  task automatic sc_literal_store;
    ex(amx_load_literal_op, 7'h00, 1'b0, 8'hff, 8'hff, 1'b0);
    ex(amx_store_accumulator_op, 7'h00, 1'b0, 8'h00, 8'hff, 1'b0);
    ex(amx_load_literal_op, 7'h00, 1'b0, 8'h00, 8'h00, 1'b0);
    ex(amx_store_accumulator_op, 7'h7f, 1'b0, 8'h00, 8'h00, 1'b0);
  endtask : sc_literal_store
  // increment wraps ff to 00 with the zero flag set, to either destination
  task automatic sc_increment;
    ex(amx_increment_file_op, 7'h00, 1'b0, 8'h00, 8'h00, 1'b1);
    peek(7'h00, 8'hff);
    ex(amx_load_literal_op, 7'h00, 1'b0, 8'h5a, 8'h5a, 1'b1);
    ex(amx_increment_file_op, 7'h00, 1'b1, 8'h00, 8'h5a, 1'b1);
    ex(amx_increment_file_op, 7'h00, 1'b1, 8'h00, 8'h5a, 1'b0);
    peek(7'h00, 8'h01);
  endtask : sc_increment
  // or into the accumulator and into a register, then move both ways
  task automatic sc_or_move;
    ex(amx_or_accumulator_with_file_op, 7'h00, 1'b0, 8'h00, 8'h5b, 1'b0);
    ex(amx_or_accumulator_with_file_op, 7'h7f, 1'b1, 8'h00, 8'h5b, 1'b0);
    ex(amx_move_file_op, 7'h7f, 1'b1, 8'h00, 8'h5b, 1'b0);
    peek(7'h7f, 8'h5b);
    ex(amx_move_file_op, 7'h00, 1'b0, 8'h00, 8'h01, 1'b0);
  endtask : sc_or_move
  // zero test by write-back, then a read of the same register
  task automatic sc_zero_test;
    ex(amx_load_literal_op, 7'h00, 1'b0, 8'h00, 8'h00, 1'b0);
    ex(amx_store_accumulator_op, 7'h02, 1'b0, 8'h00, 8'h00, 1'b0);
    ex(amx_move_file_op, 7'h02, 1'b1, 8'h00, 8'h00, 1'b1);
    ex(amx_move_file_op, 7'h02, 1'b0, 8'h00, 8'h00, 1'b1);
    ex(amx_or_accumulator_with_file_op, 7'h02, 1'b0, 8'h00, 8'h00, 1'b1);
  endtask : sc_zero_test
  // idle and an undefined code change nothing but still complete
  task automatic sc_idle;
    ex(amx_idle_op, 7'h02, 1'b1, 8'hff, 8'h00, 1'b1);
    ex(amx_op_type'(3'h7), 7'h00, 1'b1, 8'hff, 8'h00, 1'b1);
    peek(7'h02, 8'h00);
    op_valid = 1'b0;
    @(negedge ref_clk);
    chk({7'h00, op_done}, 8'h00);
  endtask : sc_idle
  // reset in mid-run clears the registers; the file array keeps its contents
  task automatic sc_mid_reset;
    ex(amx_load_literal_op, 7'h00, 1'b0, 8'ha5, 8'ha5, 1'b1);
    op_valid = 1'b0;
    reset = 1'b1;
    @(negedge ref_clk);
    chk(accum, amx_accum_reset);
    chk({6'h00, zero_flag, op_done}, {6'h00, amx_zero_reset, 1'b0});
    chk(file_peek, amx_file_reset);
    reset = 1'b0;
    @(negedge ref_clk);
    chk(accum, amx_accum_reset);
    chk({6'h00, zero_flag, op_done}, {6'h00, amx_zero_reset, 1'b0});
    ex(amx_increment_file_op, 7'h7f, 1'b0, 8'h00, 8'h5c, 1'b0);
  endtask : sc_mid_reset
  initial
  begin
    sc_reset();
    sc_literal_store();
    sc_increment();
    sc_or_move();
    sc_zero_test();
    sc_idle();
    sc_mid_reset();
    summarize();
  end
endmodule : test_accumulator_move_inc_or_exec
`default_nettype wire
